// *** hdl/sfp_channel.v ***
`timescale 1ns/10ps
`include "sfp_regs.vh"

// How it works
// - channel reset returns both pointers to zero
// - reset: full flags high, empty flags low
// - reset clears output, loads default offsets
// - write clock starts writes, updates full flags
// - clocks may be asynchronous or shared
// - flag mode: first enable low writes
// - words stored sequentially, independent of reads
// - full: flag low, writes ignored
// - full flag releases on write clock after read
// - both read enables low load output
// - either read enable high holds output
// - empty flags on read clock; empty ignores reads
// - output enable low drives, high floats outputs
// - dual pin high at reset: second enable
// - two-enable mode: first low, second high
// - dual pin low at reset: offset mode
// - load strobe writes four offsets in rotation
// - offset position kept between load bursts
// - offsets read back in same rotation
// - nine-bit words captured per write
// - empty when the array word count is zero
// - almost-empty at or below empty offset
// - almost-full at full minus full offset
module sfp_channel #(
  parameter DEPTH_LOG2 = 8,
  parameter BUF_LOG2 = 4
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire reset_n_i,
  input wire write_clock_i,
  input wire read_clock_i,
  input wire [8:0] write_data_i,
  input wire write_enable_first_n_i,
  input wire write_enable_second_or_load_i,
  input wire read_enable_first_n_i,
  input wire read_enable_second_n_i,
  input wire output_enable_n_i,
  output wire [8:0] read_data_o,
  output wire [8:0] read_data_oe_o,
  output wire empty_flag_n_o,
  output wire full_flag_n_o,
  output wire almost_empty_flag_n_o,
  output wire almost_full_flag_n_o
);

localparam DEPTH = 1 << DEPTH_LOG2;
// DEPTH_LOG2 from 8 to 13, BUF_LOG2 not above DEPTH_LOG2
localparam [DEPTH_LOG2:0] DEPTH_V = {1'b1, {DEPTH_LOG2{1'b0}}};
localparam [DEPTH_LOG2:0] ZERO_V = {(DEPTH_LOG2+1){1'b0}};
localparam [DEPTH_LOG2:0] ONE_V = {{DEPTH_LOG2{1'b0}}, 1'b1};

// pin sampling
wire [`SFP_PIN_W-1:0] pins_w;
reg [`SFP_PIN_W-1:0] meta_ff;
reg [`SFP_PIN_W-1:0] pin_ff;
reg wclk_d_ff;
reg rclk_d_ff;

// decoded pin levels and events
wire chan_rst;
wire wr_evt;
wire rd_evt;
wire we1_n;
wire we2_ld;
wire re_on;
wire [8:0] wdata;

// mode and offset registers
reg two_we_ff;
reg [1:0] sel_ff;
wire [4*`SFP_OFF_W-1:0] off_q;
wire [15:0] empty_off;
wire [15:0] full_off;
wire [DEPTH_LOG2:0] n_eff;
wire [DEPTH_LOG2:0] m_eff;

// request decode
wire fifo_wr_req;
wire off_wr_fire;
wire off_rd_fire;
wire wr_accept;
wire fifo_rd;

// storage
reg [8:0] mem [0:DEPTH-1];
reg [DEPTH_LOG2-1:0] wptr_ff;
reg [DEPTH_LOG2-1:0] rptr_ff;
reg [DEPTH_LOG2:0] arr_level_ff;
wire buf_in_ready;
wire buf_out_valid;
wire [8:0] buf_out_data;
wire [BUF_LOG2:0] buf_level;
wire arr_room;
wire drain;
wire [DEPTH_LOG2:0] tot_lvl;
wire [DEPTH_LOG2:0] tot_after;
wire [DEPTH_LOG2:0] arr_after;

// outputs
reg [8:0] out_ff;
reg [8:0] oe_ff;
reg empty_n_ff;
reg full_n_ff;
reg aempty_n_ff;
reg afull_n_ff;

assign pins_w = {reset_n_i, write_clock_i, read_clock_i, write_data_i,
                 write_enable_first_n_i, write_enable_second_or_load_i,
                 read_enable_first_n_i, read_enable_second_n_i, output_enable_n_i};

// both port clocks are sampled, so shared or unrelated clocks behave alike;
// each pin clock phase must last at least two system clock periods
always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    meta_ff <= `SFP_PIN_RST_VAL;
    pin_ff <= `SFP_PIN_RST_VAL;
    wclk_d_ff <= 1'b0;
    rclk_d_ff <= 1'b0;
  end else begin
    meta_ff <= pins_w;
    pin_ff <= meta_ff;
    wclk_d_ff <= pin_ff[`SFP_PIN_WCLK];
    rclk_d_ff <= pin_ff[`SFP_PIN_RCLK];
  end
end

assign chan_rst = ~pin_ff[`SFP_PIN_RST];
assign wr_evt = pin_ff[`SFP_PIN_WCLK] & ~wclk_d_ff;
assign rd_evt = pin_ff[`SFP_PIN_RCLK] & ~rclk_d_ff;
assign we1_n = pin_ff[`SFP_PIN_WE1];
assign we2_ld = pin_ff[`SFP_PIN_WE2];
assign re_on = ~pin_ff[`SFP_PIN_RE1] & ~pin_ff[`SFP_PIN_RE2];
assign wdata = pin_ff[`SFP_PIN_DATA_MSB:`SFP_PIN_DATA_LSB];

// dual pin strap, followed for the whole reset pulse
always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    two_we_ff <= 1'b0;
  end else if (chan_rst) begin
    two_we_ff <= we2_ld;
  end
end

// in both modes a word enters the FIFO when the first enable is low and the
// dual pin high: a second enable in one mode, an idle load strobe in the other
assign fifo_wr_req = ~we1_n & we2_ld;
assign wr_accept = wr_evt & ~chan_rst & fifo_wr_req & full_n_ff & buf_in_ready;
assign off_wr_fire = wr_evt & ~chan_rst & ~two_we_ff & ~we1_n & ~we2_ld;
assign off_rd_fire = rd_evt & ~chan_rst & ~two_we_ff & ~we2_ld & re_on;
// reads are gated by the registered flag, so a freshly written word only
// becomes readable after the read edge that lifts the empty flag
assign fifo_rd = rd_evt & ~chan_rst & re_on & (two_we_ff | we2_ld) & empty_n_ff;

// offset registers, one per rotation slot
genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : gen_off
    localparam [7:0] DEF = (g == `SFP_IDX_EMPTY_LO) ? `SFP_RST_EMPTY_LO :
                           (g == `SFP_IDX_EMPTY_HI) ? `SFP_RST_EMPTY_HI :
                           (g == `SFP_IDX_FULL_LO) ? `SFP_RST_FULL_LO : `SFP_RST_FULL_HI;
    reg [7:0] val_ff;
    always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        val_ff <= DEF;
      end else if (chan_rst) begin
        val_ff <= DEF;
      end else if (off_wr_fire && (sel_ff == g)) begin
        val_ff <= wdata[7:0];
      end
    end
    assign off_q[g*`SFP_OFF_W +: `SFP_OFF_W] = val_ff;
  end
endgenerate

// one rotation pointer serves loading and read-back; a load and a read in
// the same cycle use the same slot and advance it once
always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    sel_ff <= 2'd0;
  end else if (chan_rst) begin
    sel_ff <= 2'd0;
  end else if (off_wr_fire | off_rd_fire) begin
    sel_ff <= sel_ff + 2'd1;
  end
end

assign empty_off = {off_q[`SFP_IDX_EMPTY_HI*`SFP_OFF_W +: `SFP_OFF_W],
                    off_q[`SFP_IDX_EMPTY_LO*`SFP_OFF_W +: `SFP_OFF_W]};
assign full_off = {off_q[`SFP_IDX_FULL_HI*`SFP_OFF_W +: `SFP_OFF_W],
                   off_q[`SFP_IDX_FULL_LO*`SFP_OFF_W +: `SFP_OFF_W]};
// offset bits above the pointer width are ignored
assign n_eff = {1'b0, empty_off[DEPTH_LOG2-1:0]};
assign m_eff = {1'b0, full_off[DEPTH_LOG2-1:0]};

// staging buffer between the write port and the array
sfp_buf #(
  .WIDTH(`SFP_DATA_W),
  .DEPTH_LOG2(BUF_LOG2)
) u_buf (
  .sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i),
  .clr_i(chan_rst),
  .in_valid_i(wr_accept),
  .in_ready_o(buf_in_ready),
  .in_data_i(wdata),
  .out_valid_o(buf_out_valid),
  .out_ready_i(arr_room),
  .out_data_o(buf_out_data),
  .level_o(buf_level)
);

assign arr_room = (arr_level_ff != DEPTH_V);
assign drain = buf_out_valid & arr_room;

// staged words count toward full so the array can never be overrun
assign tot_lvl = arr_level_ff + {{(DEPTH_LOG2-BUF_LOG2){1'b0}}, buf_level};
assign tot_after = tot_lvl + {{DEPTH_LOG2{1'b0}}, wr_accept} - {{DEPTH_LOG2{1'b0}}, fifo_rd};
assign arr_after = arr_level_ff + {{DEPTH_LOG2{1'b0}}, drain} - {{DEPTH_LOG2{1'b0}}, fifo_rd};

always @(posedge sys_clk_i) begin
  if (drain) begin
    mem[wptr_ff] <= buf_out_data;
  end
end

always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    wptr_ff <= {DEPTH_LOG2{1'b0}};
    rptr_ff <= {DEPTH_LOG2{1'b0}};
    arr_level_ff <= ZERO_V;
  end else if (chan_rst) begin
    wptr_ff <= {DEPTH_LOG2{1'b0}};
    rptr_ff <= {DEPTH_LOG2{1'b0}};
    arr_level_ff <= ZERO_V;
  end else begin
    if (drain) begin
      wptr_ff <= wptr_ff + ONE_V[DEPTH_LOG2-1:0];
    end
    if (fifo_rd) begin
      rptr_ff <= rptr_ff + ONE_V[DEPTH_LOG2-1:0];
    end
    arr_level_ff <= arr_after;
  end
end

// output register
always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    out_ff <= `SFP_RST_OUT;
  end else if (chan_rst) begin
    out_ff <= `SFP_RST_OUT;
  end else if (fifo_rd) begin
    out_ff <= mem[rptr_ff];
  end else if (off_rd_fire) begin
    out_ff <= {1'b0, off_q[sel_ff*`SFP_OFF_W +: `SFP_OFF_W]};
  end
  // otherwise held, including while either read enable is high
end

always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    oe_ff <= 9'h000;
  end else begin
    oe_ff <= {9{~pin_ff[`SFP_PIN_OE]}};
  end
end

// write-side flags move only on write clock edges, so after a read frees
// space the full flag lifts at the next write edge, whose write is refused
always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    full_n_ff <= 1'b1;
    afull_n_ff <= 1'b1;
  end else if (chan_rst) begin
    full_n_ff <= 1'b1;
    afull_n_ff <= 1'b1;
  end else if (wr_evt) begin
    full_n_ff <= (tot_after != DEPTH_V);
    afull_n_ff <= (tot_after < (DEPTH_V - m_eff));
  end
end

// read-side flags move only on read clock edges
always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    empty_n_ff <= 1'b0;
    aempty_n_ff <= 1'b0;
  end else if (chan_rst) begin
    empty_n_ff <= 1'b0;
    aempty_n_ff <= 1'b0;
  end else if (rd_evt) begin
    empty_n_ff <= (arr_after != ZERO_V);
    aempty_n_ff <= (arr_after > n_eff);
  end
end

assign read_data_o = out_ff;
assign read_data_oe_o = oe_ff;
assign empty_flag_n_o = empty_n_ff;
assign full_flag_n_o = full_n_ff;
assign almost_empty_flag_n_o = aempty_n_ff;
assign almost_full_flag_n_o = afull_n_ff;

endmodule

// *** pkg/sfp_regs.vh ***
`ifndef SFP_REGS_VH
`define SFP_REGS_VH

// word and offset register widths
`define SFP_DATA_W 9
`define SFP_OFF_W 8

// offset register indices, in load and read-back order
`define SFP_IDX_EMPTY_LO 2'd0
`define SFP_IDX_EMPTY_HI 2'd1
`define SFP_IDX_FULL_LO 2'd2
`define SFP_IDX_FULL_HI 2'd3

// offset register reset values: empty+7 and full-7
`define SFP_RST_EMPTY_LO 8'h07
`define SFP_RST_EMPTY_HI 8'h00
`define SFP_RST_FULL_LO 8'h07
`define SFP_RST_FULL_HI 8'h00

// bit positions in the sampled pin vector
`define SFP_PIN_W 17
`define SFP_PIN_RST 16
`define SFP_PIN_WCLK 15
`define SFP_PIN_RCLK 14
`define SFP_PIN_DATA_MSB 13
`define SFP_PIN_DATA_LSB 5
`define SFP_PIN_WE1 4
`define SFP_PIN_WE2 3
`define SFP_PIN_RE1 2
`define SFP_PIN_RE2 1
`define SFP_PIN_OE 0

// synchroniser reset value: channel in reset, enables idle
`define SFP_PIN_RST_VAL 17'h00017

// output register reset value
`define SFP_RST_OUT 9'h000

`endif

// *** hdl/sfp_buf.v ***
`timescale 1ns/10ps
module sfp_buf #(
  parameter WIDTH = 9,
  parameter DEPTH_LOG2 = 4
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire clr_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [DEPTH_LOG2:0] level_o
);

localparam DEPTH = 1 << DEPTH_LOG2;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [DEPTH_LOG2:0] wp_ff;
reg [DEPTH_LOG2:0] rp_ff;

wire [DEPTH_LOG2:0] used_w;
wire full_w;
wire empty_w;
wire push_w;
wire pop_w;

assign used_w = wp_ff - rp_ff;
// extra pointer bit tells full from empty
assign full_w = (wp_ff[DEPTH_LOG2] != rp_ff[DEPTH_LOG2]) &&
                (wp_ff[DEPTH_LOG2-1:0] == rp_ff[DEPTH_LOG2-1:0]);
assign empty_w = (wp_ff == rp_ff);
assign push_w = in_valid_i & ~full_w;
assign pop_w = out_ready_i & ~empty_w;

assign in_ready_o = ~full_w;
assign out_valid_o = ~empty_w;
assign out_data_o = mem[rp_ff[DEPTH_LOG2-1:0]];
assign level_o = used_w;

always @(posedge sys_clk_i) begin
  if (push_w) begin
    mem[wp_ff[DEPTH_LOG2-1:0]] <= in_data_i;
  end
end

always @(posedge sys_clk_i or negedge arst_n_i) begin
  if (!arst_n_i) begin
    wp_ff <= {(DEPTH_LOG2+1){1'b0}};
    rp_ff <= {(DEPTH_LOG2+1){1'b0}};
  end else if (clr_i) begin
    wp_ff <= {(DEPTH_LOG2+1){1'b0}};
    rp_ff <= {(DEPTH_LOG2+1){1'b0}};
  end else begin
    if (push_w) begin
      wp_ff <= wp_ff + {{DEPTH_LOG2{1'b0}}, 1'b1};
    end
    if (pop_w) begin
      rp_ff <= rp_ff + {{DEPTH_LOG2{1'b0}}, 1'b1};
    end
  end
end

endmodule

// *** testbench/sfp_channel_properties.sv ***
`timescale 1ns/10ps
module sfp_channel_props (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire reset_n_i,
  input wire write_clock_i,
  input wire read_clock_i,
  input wire read_enable_first_n_i,
  input wire read_enable_second_n_i,
  input wire output_enable_n_i,
  input wire [8:0] read_data_o,
  input wire [8:0] read_data_oe_o,
  input wire empty_flag_n_o,
  input wire full_flag_n_o,
  input wire almost_empty_flag_n_o,
  input wire almost_full_flag_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // pins act three edges after they are first sampled
  property p_rst_flags; !reset_n_i [*4] |-> !empty_flag_n_o && !almost_empty_flag_n_o
    && full_flag_n_o && almost_full_flag_n_o; endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("flags wrong in reset");
  property p_rst_out; !reset_n_i [*4] |-> read_data_o == 9'h000; endproperty
  a_rst_out: assert property (p_rst_out) else $error("output register not cleared");
  property p_full_afull; !full_flag_n_o |-> !almost_full_flag_n_o; endproperty
  a_full_afull: assert property (p_full_afull) else $error("full without almost-full");
  property p_empty_aempty; !empty_flag_n_o |-> !almost_empty_flag_n_o; endproperty
  a_empty_aempty: assert property (p_empty_aempty) else $error("empty without almost-empty");
  property p_out_rclk; $changed(read_data_o) |-> !$past(reset_n_i, 3) || ($past(read_clock_i, 3)
    && !$past(read_clock_i, 4) && !$past(read_enable_first_n_i, 3) && !$past(read_enable_second_n_i, 3));
  endproperty
  a_out_rclk: assert property (p_out_rclk) else $error("output changed without read");
  property p_full_wclk; $changed(full_flag_n_o) |-> !$past(reset_n_i, 3)
    || ($past(write_clock_i, 3) && !$past(write_clock_i, 4)); endproperty
  a_full_wclk: assert property (p_full_wclk) else $error("full flag moved off write clock");
  property p_empty_rclk; $changed(empty_flag_n_o) |-> !$past(reset_n_i, 3)
    || ($past(read_clock_i, 3) && !$past(read_clock_i, 4)); endproperty
  a_empty_rclk: assert property (p_empty_rclk) else $error("empty flag moved off read clock");
  property p_oe_off; output_enable_n_i [*4] |-> read_data_oe_o == 9'h000; endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven while disabled");
  property p_oe_on; !output_enable_n_i [*4] |-> read_data_oe_o == 9'h1ff; endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs not driven while enabled");
endmodule
bind sfp_channel sfp_channel_props sfp_channel_props_inst (.sys_clk_i, .arst_n_i, .reset_n_i,
  .write_clock_i, .read_clock_i, .read_enable_first_n_i, .read_enable_second_n_i, .output_enable_n_i,
  .read_data_o, .read_data_oe_o, .empty_flag_n_o, .full_flag_n_o, .almost_empty_flag_n_o,
  .almost_full_flag_n_o);

// *** testbench/sfp_port_model.sv ***
`timescale 1ns/10ps
module sfp_port_model (
  input wire sys_clk_i,
  output logic write_clock_o = 1'b0,
  output logic read_clock_o = 1'b0,
  output logic [8:0] write_data_o = 9'h000,
  output logic write_enable_first_n_o = 1'b1,
  output logic write_enable_second_or_load_o = 1'b1,
  output logic read_enable_first_n_o = 1'b1,
  output logic read_enable_second_n_o = 1'b1
);
  task cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // one transfer at a time, so offset load and read-back never share a period
  task wr(input logic [8:0] d, input logic e1, input logic e2);
    write_data_o = d;
    write_enable_first_n_o = e1;
    write_enable_second_or_load_o = e2;
    cyc(3);
    write_clock_o = 1'b1;
    cyc(3);
    write_clock_o = 1'b0;
    write_enable_first_n_o = 1'b1;
    // released data is not left looking valid
    write_data_o = ~d;
    cyc(1);
  endtask
  task rd(input logic e1, input logic e2, input logic ld);
    read_enable_first_n_o = e1;
    read_enable_second_n_o = e2;
    write_enable_second_or_load_o = ld;
    cyc(3);
    read_clock_o = 1'b1;
    cyc(3);
    read_clock_o = 1'b0;
    read_enable_first_n_o = 1'b1;
    read_enable_second_n_o = 1'b1;
    cyc(1);
  endtask
endmodule

// *** testbench/sfp_channel_tb.sv ***
`timescale 1ns/10ps
`define PM sfp_port_model_inst
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module sfp_channel_tb;
  localparam int DEPTH = 256;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic output_enable_n_i = 1'b0;
  wire write_clock_i, read_clock_i, write_enable_first_n_i, write_enable_second_or_load_i;
  wire read_enable_first_n_i, read_enable_second_n_i;
  wire [8:0] write_data_i, read_data_o, read_data_oe_o;
  wire empty_flag_n_o, full_flag_n_o, almost_empty_flag_n_o, almost_full_flag_n_o;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int i;
  logic [8:0] offs [4] = '{9'h000, 9'h003, 9'h000, 9'h002};

  sfp_channel #(.DEPTH_LOG2(8), .BUF_LOG2(4)) sfp_channel_inst (
    .sys_clk_i, .arst_n_i, .reset_n_i, .write_clock_i, .read_clock_i, .write_data_i,
    .write_enable_first_n_i, .write_enable_second_or_load_i, .read_enable_first_n_i,
    .read_enable_second_n_i, .output_enable_n_i, .read_data_o, .read_data_oe_o, .empty_flag_n_o,
    .full_flag_n_o, .almost_empty_flag_n_o, .almost_full_flag_n_o
  );
  sfp_port_model sfp_port_model_inst (
    .sys_clk_i,
    .write_clock_o(write_clock_i),
    .read_clock_o(read_clock_i),
    .write_data_o(write_data_i),
    .write_enable_first_n_o(write_enable_first_n_i),
    .write_enable_second_or_load_o(write_enable_second_or_load_i),
    .read_enable_first_n_o(read_enable_first_n_i),
    .read_enable_second_n_o(read_enable_second_n_i)
  );

  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task summarize;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      err_total++;
      $display("MISMATCH run length exp done got hang");
      summarize();
    end
  end

  // strap held across the pulse and beyond the synchroniser
  task chrst(input logic mode);
    `PM.write_enable_second_or_load_o = mode;
    reset_n_i = 1'b0;
    `PM.cyc(5);
    `CHK("ef_n", 1'b0, empty_flag_n_o)
    `CHK("ae_n", 1'b0, almost_empty_flag_n_o)
    `CHK("ff_n", 1'b1, full_flag_n_o)
    `CHK("af_n", 1'b1, almost_full_flag_n_o)
    `CHK("rdata", 9'h000, read_data_o)
    reset_n_i = 1'b1;
    `PM.cyc(5);
  endtask

  task test_oe;
    chrst(1'b1);
    `CHK("oe", 9'h1ff, read_data_oe_o)
    output_enable_n_i = 1'b1;
    `PM.cyc(4);
    `CHK("oe", 9'h000, read_data_oe_o)
    output_enable_n_i = 1'b0;
    // stale word, must vanish at the next channel reset
    `PM.wr(9'h0aa, 1'b0, 1'b1);
    $display("oe test done");
  endtask

  task test_two_enable;
    chrst(1'b1);
    `PM.wr(9'h0bb, 1'b1, 1'b1);
    `PM.wr(9'h0cc, 1'b0, 1'b0);
    for (i = 0; i < DEPTH; i++) begin
      `PM.wr(i[8:0] ^ 9'h1a5, 1'b0, 1'b1);
      `CHK("af_n", (i < DEPTH - 8), almost_full_flag_n_o)
      `CHK("ff_n", (i != DEPTH - 1), full_flag_n_o)
    end
    `PM.wr(9'h1ee, 1'b0, 1'b1);
    `PM.rd(1'b0, 1'b0, 1'b1);
    `CHK("rdata", 9'h000, read_data_o)
    `CHK("ef_n", 1'b1, empty_flag_n_o)
    `PM.rd(1'b1, 1'b0, 1'b1);
    `PM.rd(1'b0, 1'b1, 1'b1);
    `CHK("rdata", 9'h000, read_data_o)
    for (i = 0; i < DEPTH; i++) begin
      `PM.rd(1'b0, 1'b0, 1'b1);
      `CHK("rdata", i[8:0] ^ 9'h1a5, read_data_o)
      `CHK("ae_n", (DEPTH - 1 - i > 7), almost_empty_flag_n_o)
      if (i == 0) begin
        // the releasing edge itself stores nothing
        `PM.wr(9'h111, 1'b0, 1'b1);
        `CHK("ff_n", 1'b1, full_flag_n_o)
      end
    end
    `CHK("ef_n", 1'b0, empty_flag_n_o)
    `PM.rd(1'b0, 1'b0, 1'b1);
    `CHK("rdata", 9'h0ff ^ 9'h1a5, read_data_o)
    $display("two enable test done");
  endtask

  task test_offsets;
    chrst(1'b0);
    `PM.wr(9'h009, 1'b0, 1'b0);
    `PM.wr(9'h000, 1'b0, 1'b0);
    `PM.wr(9'h1e1, 1'b0, 1'b1);
    `PM.wr(9'h003, 1'b0, 1'b0);
    `PM.wr(9'h000, 1'b0, 1'b0);
    `PM.wr(9'h102, 1'b0, 1'b0);
    `PM.wr(9'h1e2, 1'b1, 1'b1);
    for (i = 0; i < 4; i++) begin
      `PM.rd(1'b0, 1'b0, 1'b0);
      `CHK("offset", offs[i], read_data_o)
    end
    // offset read-back edges already lifted the empty flag, so the next read pops
    `PM.wr(9'h1e3, 1'b0, 1'b1);
    `PM.wr(9'h1e4, 1'b0, 1'b1);
    `PM.wr(9'h1e5, 1'b0, 1'b1);
    `PM.rd(1'b0, 1'b0, 1'b1);
    `CHK("ae_n", 1'b1, almost_empty_flag_n_o)
    `CHK("rdata", 9'h1e1, read_data_o)
    `PM.rd(1'b0, 1'b0, 1'b1);
    `CHK("rdata", 9'h1e3, read_data_o)
    `CHK("ae_n", 1'b0, almost_empty_flag_n_o)
    `PM.rd(1'b0, 1'b0, 1'b1);
    `CHK("rdata", 9'h1e4, read_data_o)
    $display("offset test done");
  endtask

  initial begin
    repeat (4) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    test_oe();
    test_two_enable();
    test_offsets();
    summarize();
  end
endmodule
